// file: pkg/gtc_cfg.svh
/*
  Fixed offsets, field positions, reset values and counts of the transmit
  collision control block.
  Assumes it is included by bare name wherever a constant is needed.
*/
`ifndef GTC_CFG_SVH
`define GTC_CFG_SVH

// Register byte offsets.
`define GTC_OFS_TCTL 16'h0400
`define GTC_OFS_TX_CONTROL_EXTENSION 16'h0404
`define GTC_OFS_MODE 16'h0408
`define GTC_OFS_STAT 16'h040c

// Transmit control field positions.
`define GTC_CT_LO 4
`define GTC_CT_HI 11
`define GTC_COLLISION_DISTANCE_LO 12
`define GTC_COLLISION_DISTANCE_HI 21
`define GTC_SWP_BIT 22
`define GTC_LATE_COLLISION_RETRY_EN_BIT 24
`define GTC_TXCS_LO 26
`define GTC_TXCS_HI 27
`define GTC_MULTI_READ_REQUEST_EN_BIT 28

// Extended control collision distance field.
`define GTC_XCOLD_LO 10
`define GTC_XCOLD_HI 19

// Mode register field positions.
`define GTC_FD_BIT 0
`define GTC_SPD_LO 1
`define GTC_SPD_HI 2

// Reset values.
`define GTC_CT_RST 8'h00
`define GTC_COLLISION_DISTANCE_RST 10'h000
`define GTC_XCOLD_RST 10'h000
`define GTC_MULTI_READ_REQUEST_EN_RST 1'b1

// Configuration word bit that loads the multi-request enable.
`define GTC_NVM_MULTI_READ_REQUEST_EN_BIT 14

// Outstanding read limits.
`define GTC_REQ_ONE 3'h1
`define GTC_REQ_FOUR 3'h4

// Late collision windows in bytes.
`define GTC_WIN_SLOW 16'h0040
`define GTC_WIN_GIG 16'h0200

// Retry saturation and back-off exponent cap.
`define GTC_RETRY_MAX 5'h10
`define GTC_BACKOFF_CAP 5'h0a

// Carrier extension symbol on the data lines.
`define GTC_EXT_SYM 8'h0f

`endif

// file: pkg/gtc_pkg.sv
/*
  Types shared by the transmit collision control block.
  Assumes gtc_cfg.svh holds the numeric constants.
*/
package gtc_pkg;

  // Link speed of the attached physical layer.
  typedef enum logic [1:0] {
    GTC_SPD_10 = 2'b00,
    GTC_SPD_100 = 2'b01,
    GTC_SPD_1000 = 2'b10
  } gtc_speed_t;

  // Transmit sequencer states.
  typedef enum logic [1:0] {
    GTC_S_IDLE = 2'b00,
    GTC_S_DATA = 2'b01,
    GTC_S_EXT = 2'b10,
    GTC_S_BACKOFF = 2'b11
  } gtc_state_t;

  // One byte of packet data from the fetch side.
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } gtc_beat_t;

  // Byte-wide transmit symbol toward the physical layer.
  typedef struct packed {
    logic en;
    logic er;
    logic [7:0] data;
  } gtc_gmii_t;

endpackage

// file: hw/gtc_req_limit.sv
/*
  Limiter for outstanding transmit-data read requests.
  Assumes want and done come from logic on clk_sys and that the enable
  only changes while no transmit work is pending.
*/
`timescale 1ns/100ps
`include "gtc_cfg.svh"

module gtc_req_limit
  import gtc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic multi_en,
  input wire logic want,
  input wire logic done,
  output logic req,
  output logic [2:0] count
);

  logic req_r;
  logic [2:0] cnt_r;
  logic [2:0] limit;
  logic issue;
  logic retire;

  // One request at a time unless the multi-request enable is set.
  assign limit = multi_en ? `GTC_REQ_FOUR : `GTC_REQ_ONE;
  assign issue = want && (cnt_r < limit);
  assign retire = done && (cnt_r != 3'h0);

  // The counter already holds a request in the cycle it is issued.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_r <= 1'b0;
      cnt_r <= 3'h0;
    end
    else
    begin
      req_r <= issue;
      cnt_r <= cnt_r + {2'h0, issue} - {2'h0, retire};
    end
  end

  assign req = req_r;
  assign count = cnt_r;

  property p_single;
    @(posedge clk_sys) disable iff (!rst_n)
    !multi_en |-> cnt_r <= `GTC_REQ_ONE;
  endproperty
  a_single: assert property (p_single) else $error("second read issued in single mode");

  property p_quad;
    @(posedge clk_sys) disable iff (!rst_n)
    req_r |-> cnt_r <= `GTC_REQ_FOUR && cnt_r != 3'h0;
  endproperty
  a_quad: assert property (p_quad) else $error("outstanding reads out of range");

  c_four: cover property (@(posedge clk_sys) disable iff (!rst_n) cnt_r == 3'h4);

endmodule

// file: hw/gtc_late_col.sv
/*
  Late collision classification for the transmit sequencer.
  Assumes bytes counts symbols already sent in the current attempt.
*/
`timescale 1ns/100ps
`include "gtc_cfg.svh"

module gtc_late_col
  import gtc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [15:0] bytes,
  input wire gtc_speed_t speed,
  input wire logic full_duplex,
  input wire logic retry_en,
  output logic late,
  output logic retry_ok
);

  logic [15:0] window;

  // The collision window depends on the link speed.
  assign window = (speed == GTC_SPD_1000) ? `GTC_WIN_GIG : `GTC_WIN_SLOW;
  assign late = bytes >= window;
  // In half duplex early collisions always retry and late ones only with the enable; none retry in full duplex.
  assign retry_ok = !full_duplex && (!late || retry_en);

  property p_gig_win;
    @(posedge clk_sys) disable iff (!rst_n)
    speed == GTC_SPD_1000 |-> late == (bytes >= `GTC_WIN_GIG);
  endproperty
  a_gig_win: assert property (p_gig_win) else $error("gigabit late window wrong");

  property p_no_late_retry;
    @(posedge clk_sys) disable iff (!rst_n)
    late && !retry_en |-> !retry_ok;
  endproperty
  a_no_late_retry: assert property (p_no_late_retry) else $error("late retry without enable");

  property p_fd_ignore;
    @(posedge clk_sys) disable iff (!rst_n)
    full_duplex |-> !retry_ok;
  endproperty
  a_fd_ignore: assert property (p_fd_ignore) else $error("retry allowed in full duplex");

endmodule

// file: hw/gtc_tx_ctrl.sv
/*
  Transmit control of a gigabit MAC: register file, read-request limit,
  collision handling with retry and abort, carrier extension padding,
  and software pause requests.
  Assumes the packet source streams one byte per cycle without gaps and
  restarts a packet on a retry pulse; the collision pin is asynchronous.
*/
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
`include "gtc_cfg.svh"

// Function
// - One read outstanding normally; up to four with multi-request enable.
// - Multi-request enable resets to one, then loads from configuration bit 14.
// - Control bits 31 to 29 read zero; software writes zero.
// - Abort the packet once the collision threshold is reached.
// - Pad short packets with extension symbols, not data bytes.
// - Padding check applies in full and half duplex.
// - Strip extension symbols when running at 100 Mb/s.
// - Software pause request is sent whatever the duplex setting.
// - With late retry enabled, retransmit after a late collision.
// - Late means 64 bytes sent at 10/100, 512 at gigabit.
// - Late collision without retry enable counts as success.
// - Full duplex ignores the late retry enable.
// - Extended register bits 19 to 10 hold collision distance, reset zero.
// - Pause request is bit 22, uses pause timer, self-clears when sent.
// - Late collision retry enable is control bit 24.
// - Back-off saturates after ten retries; threshold matters in half duplex.
module gtc_tx_ctrl
  import gtc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic nvm_load,
  input wire logic [15:0] nvm_word,
  input wire logic fetch_want,
  input wire logic fetch_done,
  output logic fetch_req,
  input wire gtc_beat_t src_beat,
  input wire logic src_valid,
  output logic src_ready,
  output gtc_gmii_t phy_tx,
  input wire logic phy_col,
  output logic pkt_done,
  output logic pkt_retry,
  output logic pkt_abort,
  input wire logic [15:0] pause_timer_value,
  input wire logic pause_sent,
  output logic pause_req,
  output logic [15:0] pause_time
);

  logic [7:0] ct_r;
  logic [9:0] collision_distance_r;
  logic [1:0] txcs_r;
  logic late_collision_retry_en_r;
  logic sw_pause_r;
  logic multi_en_r;
  logic [9:0] xcold_r;
  logic full_duplex_r;
  gtc_speed_t speed_r;
  logic [31:0] rdata_r;
  logic col_s1_r;
  logic col_s2_r;
  logic col_s3_r;
  logic col_q_r;
  gtc_state_t state_r;
  gtc_state_t state_nxt;
  logic [15:0] bytes_r;
  logic [4:0] attempt_r;
  logic [15:0] backoff_r;
  logic [15:0] backoff_nxt;
  logic [15:0] lfsr_r;
  logic src_ready_r;
  gtc_gmii_t phy_tx_r;
  logic done_r;
  logic retry_r;
  logic abort_r;
  logic pause_req_r;
  logic [15:0] pause_time_r;
  logic wr_tctl;
  logic wr_xtctl;
  logic wr_mode;
  logic [9:0] collision_distance_eff;
  logic col_hit;
  logic col_evt;
  logic col_act;
  logic lc_late;
  logic lc_retry_ok;
  logic thresh_hit;
  logic beat_take;
  logic pad_need;
  logic pad_more;
  logic pkt_end;
  logic [2:0] out_cnt;
  logic [4:0] bo_exp;
  logic [9:0] bo_mask;

  // Register write decode.
  assign wr_tctl = reg_wr && (reg_addr == `GTC_OFS_TCTL);
  assign wr_xtctl = reg_wr && (reg_addr == `GTC_OFS_TX_CONTROL_EXTENSION);
  assign wr_mode = reg_wr && (reg_addr == `GTC_OFS_MODE);

  // Transmit control fields; reserved bits are not stored.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ct_r <= `GTC_CT_RST;
      collision_distance_r <= `GTC_COLLISION_DISTANCE_RST;
      txcs_r <= 2'h0;
      late_collision_retry_en_r <= 1'b0;
    end
    else if (wr_tctl)
    begin
      ct_r <= reg_wdata[`GTC_CT_HI:`GTC_CT_LO];
      collision_distance_r <= reg_wdata[`GTC_COLLISION_DISTANCE_HI:`GTC_COLLISION_DISTANCE_LO];
      txcs_r <= reg_wdata[`GTC_TXCS_HI:`GTC_TXCS_LO];
      late_collision_retry_en_r <= reg_wdata[`GTC_LATE_COLLISION_RETRY_EN_BIT];
    end
  end

  // Pause request: a software set wins over the self-clear when the frame goes out.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      sw_pause_r <= 1'b0;
    else if (wr_tctl && reg_wdata[`GTC_SWP_BIT])
      sw_pause_r <= 1'b1;
    else if (pause_sent || wr_tctl)
      sw_pause_r <= 1'b0;
  end

  // Multi-request enable resets to one and is then loaded from the configuration word.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      multi_en_r <= `GTC_MULTI_READ_REQUEST_EN_RST;
    else if (nvm_load)
      multi_en_r <= nvm_word[`GTC_NVM_MULTI_READ_REQUEST_EN_BIT];
    else if (wr_tctl)
      multi_en_r <= reg_wdata[`GTC_MULTI_READ_REQUEST_EN_BIT];
  end

  // Extended collision distance and link mode.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xcold_r <= `GTC_XCOLD_RST;
      full_duplex_r <= 1'b0;
      speed_r <= GTC_SPD_1000;
    end
    else
    begin
      if (wr_xtctl)
        xcold_r <= reg_wdata[`GTC_XCOLD_HI:`GTC_XCOLD_LO];
      if (wr_mode)
      begin
        full_duplex_r <= reg_wdata[`GTC_FD_BIT];
        speed_r <= gtc_speed_t'(reg_wdata[`GTC_SPD_HI:`GTC_SPD_LO]);
      end
    end
  end

  // Read data stand in the cycle after the strobe; unmapped addresses read zero.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= 32'h0;
    else if (reg_rd)
    begin
      rdata_r <= 32'h0;
      case (reg_addr)
        `GTC_OFS_TCTL:
        begin
          rdata_r[`GTC_CT_HI:`GTC_CT_LO] <= ct_r;
          rdata_r[`GTC_COLLISION_DISTANCE_HI:`GTC_COLLISION_DISTANCE_LO] <= collision_distance_r;
          rdata_r[`GTC_SWP_BIT] <= sw_pause_r;
          rdata_r[`GTC_LATE_COLLISION_RETRY_EN_BIT] <= late_collision_retry_en_r;
          rdata_r[`GTC_TXCS_HI:`GTC_TXCS_LO] <= txcs_r;
          rdata_r[`GTC_MULTI_READ_REQUEST_EN_BIT] <= multi_en_r;
        end
        `GTC_OFS_TX_CONTROL_EXTENSION: rdata_r[`GTC_XCOLD_HI:`GTC_XCOLD_LO] <= xcold_r;
        `GTC_OFS_MODE:
        begin
          rdata_r[`GTC_FD_BIT] <= full_duplex_r;
          rdata_r[`GTC_SPD_HI:`GTC_SPD_LO] <= speed_r;
        end
        `GTC_OFS_STAT: rdata_r[10:0] <= {sw_pause_r, state_r, attempt_r, out_cnt};
        default: rdata_r <= 32'h0;
      endcase
    end
  end

  // Three-stage synchroniser; the level is taken once stages two and three agree.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      col_s1_r <= 1'b0;
      col_s2_r <= 1'b0;
      col_s3_r <= 1'b0;
      col_q_r <= 1'b0;
    end
    else
    begin
      col_s1_r <= phy_col;
      col_s2_r <= col_s1_r;
      col_s3_r <= col_s2_r;
      if (col_s2_r == col_s3_r)
        col_q_r <= col_s3_r;
    end
  end

  gtc_late_col u_late
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .bytes(bytes_r),
    .speed(speed_r),
    .full_duplex(full_duplex_r),
    .retry_en(late_collision_retry_en_r),
    .late(lc_late),
    .retry_ok(lc_retry_ok)
  );

  gtc_req_limit u_limit
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .multi_en(multi_en_r),
    .want(fetch_want),
    .done(fetch_done),
    .req(fetch_req),
    .count(out_cnt)
  );

  // Collision decode; collisions mean nothing in full duplex.
  assign col_hit = (col_s2_r == col_s3_r) && col_s3_r && !col_q_r;
  assign col_evt = col_hit && !full_duplex_r &&
                   (state_r == GTC_S_DATA || state_r == GTC_S_EXT);
  assign col_act = col_evt && lc_retry_ok;
  assign thresh_hit = ({3'h0, attempt_r} + 8'h01) >= ct_r;

  // The extended field, when programmed, overrides the base collision distance.
  assign collision_distance_eff = (xcold_r != 10'h000) ? xcold_r : collision_distance_r;
  assign beat_take = src_valid && src_ready_r && (state_r == GTC_S_DATA);
  // Padding is checked in either duplex and dropped below gigabit.
  assign pad_need = (speed_r == GTC_SPD_1000) &&
                    ((bytes_r + 16'h0001) <= {6'h00, collision_distance_eff});
  assign pad_more = (bytes_r + 16'h0001) <= {6'h00, collision_distance_eff};
  assign pkt_end = !col_act && ((beat_take && src_beat.last && !pad_need) ||
                   (state_r == GTC_S_EXT && !pad_more));

  // Back-off window doubles per retry and stops growing at the cap.
  assign bo_exp = (attempt_r >= `GTC_BACKOFF_CAP) ? `GTC_BACKOFF_CAP : attempt_r + 5'h01;
  assign bo_mask = 10'h3ff >> (`GTC_BACKOFF_CAP - bo_exp);
  assign backoff_nxt = {lfsr_r[9:0] & bo_mask, 6'h00};

  // Sequencer next state.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      GTC_S_IDLE:
        if (src_valid)
          state_nxt = GTC_S_DATA;
      GTC_S_DATA:
        if (col_act)
          state_nxt = thresh_hit ? GTC_S_IDLE : GTC_S_BACKOFF;
        else if (beat_take && src_beat.last)
          state_nxt = pad_need ? GTC_S_EXT : GTC_S_IDLE;
      GTC_S_EXT:
        if (col_act)
          state_nxt = thresh_hit ? GTC_S_IDLE : GTC_S_BACKOFF;
        else if (!pad_more)
          state_nxt = GTC_S_IDLE;
      GTC_S_BACKOFF:
        if (backoff_r == 16'h0000)
          state_nxt = GTC_S_IDLE;
      default: state_nxt = GTC_S_IDLE;
    endcase
  end

  // State, byte count and back-off timer.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= GTC_S_IDLE;
      bytes_r <= 16'h0000;
      backoff_r <= 16'h0000;
      lfsr_r <= 16'hace1;
    end
    else
    begin
      state_r <= state_nxt;
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      if (state_nxt == GTC_S_IDLE || state_nxt == GTC_S_BACKOFF)
        bytes_r <= 16'h0000;
      else if (beat_take || state_r == GTC_S_EXT)
        bytes_r <= bytes_r + 16'h0001;
      if (col_act && !thresh_hit)
        backoff_r <= backoff_nxt;
      else if (state_r == GTC_S_BACKOFF && backoff_r != 16'h0000)
        backoff_r <= backoff_r - 16'h0001;
    end
  end

  // Attempt count saturates and clears when a packet ends or is abandoned.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      attempt_r <= 5'h00;
    else if (pkt_end || (col_act && thresh_hit))
      attempt_r <= 5'h00;
    else if (col_act && attempt_r != `GTC_RETRY_MAX)
      attempt_r <= attempt_r + 5'h01;
  end

  // Outputs toward the source and the physical layer.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      src_ready_r <= 1'b0;
      phy_tx_r <= '0;
      done_r <= 1'b0;
      retry_r <= 1'b0;
      abort_r <= 1'b0;
    end
    else
    begin
      src_ready_r <= (state_nxt == GTC_S_DATA) && !(col_act || (beat_take && src_beat.last));
      phy_tx_r <= '0;
      if (beat_take && !col_act)
      begin
        phy_tx_r.en <= 1'b1;
        phy_tx_r.data <= src_beat.data;
      end
      else if (state_r == GTC_S_EXT && !col_act)
      begin
        phy_tx_r.er <= 1'b1;
        phy_tx_r.data <= `GTC_EXT_SYM;
      end
      done_r <= pkt_end;
      retry_r <= col_act && !thresh_hit;
      abort_r <= col_act && thresh_hit;
    end
  end

  // Pause frame request follows the bit with no duplex gating.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pause_req_r <= 1'b0;
      pause_time_r <= 16'h0000;
    end
    else
    begin
      pause_req_r <= sw_pause_r && !pause_sent;
      pause_time_r <= pause_timer_value;
    end
  end

  assign reg_rdata = rdata_r;
  assign src_ready = src_ready_r;
  assign phy_tx = phy_tx_r;
  assign pkt_done = done_r;
  assign pkt_retry = retry_r;
  assign pkt_abort = abort_r;
  assign pause_req = pause_req_r;
  assign pause_time = pause_time_r;

  property p_rsv_zero;
    @(posedge clk_sys) disable iff (!rst_n)
    reg_rd && reg_addr == `GTC_OFS_TCTL |=> reg_rdata[31:29] == 3'h0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits read nonzero");

  property p_nvm_load;
    @(posedge clk_sys) disable iff (!rst_n)
    nvm_load |=> multi_en_r == $past(nvm_word[`GTC_NVM_MULTI_READ_REQUEST_EN_BIT]);
  endproperty
  a_nvm_load: assert property (p_nvm_load) else $error("enable not loaded from word");

  property p_abort;
    @(posedge clk_sys) disable iff (!rst_n)
    col_act && thresh_hit |=> pkt_abort && !pkt_retry && state_r == GTC_S_IDLE;
  endproperty
  a_abort: assert property (p_abort) else $error("threshold reached without abort");

  property p_ext_sym;
    @(posedge clk_sys) disable iff (!rst_n)
    state_r == GTC_S_EXT && !col_act |=> phy_tx.er && !phy_tx.en && phy_tx.data == `GTC_EXT_SYM;
  endproperty
  a_ext_sym: assert property (p_ext_sym) else $error("padding not extension symbol");

  property p_strip;
    @(posedge clk_sys) disable iff (!rst_n)
    state_r == GTC_S_DATA && state_nxt == GTC_S_EXT |-> speed_r == GTC_SPD_1000;
  endproperty
  a_strip: assert property (p_strip) else $error("extension sent below gigabit");

  property p_pause_any_duplex;
    @(posedge clk_sys) disable iff (!rst_n)
    sw_pause_r && !pause_sent |=> pause_req;
  endproperty
  a_pause_any_duplex: assert property (p_pause_any_duplex) else $error("pause not requested");

  property p_pause_clear;
    @(posedge clk_sys) disable iff (!rst_n)
    pause_sent && !wr_tctl |=> !sw_pause_r ##1 !pause_req;
  endproperty
  a_pause_clear: assert property (p_pause_clear) else $error("pause bit not self-cleared");

  property p_fd_no_col;
    @(posedge clk_sys) disable iff (!rst_n)
    full_duplex_r |=> !pkt_retry && !pkt_abort;
  endproperty
  a_fd_no_col: assert property (p_fd_no_col) else $error("collision acted on in full duplex");

  property p_sat;
    @(posedge clk_sys) disable iff (!rst_n)
    attempt_r == `GTC_RETRY_MAX && col_act && !thresh_hit |=> attempt_r == `GTC_RETRY_MAX;
  endproperty
  a_sat: assert property (p_sat) else $error("retry count passed saturation");

  c_pad: cover property (@(posedge clk_sys) disable iff (!rst_n) state_r == GTC_S_EXT ##1 pkt_done);
  c_retry: cover property (@(posedge clk_sys) disable iff (!rst_n) pkt_retry);
  c_abort: cover property (@(posedge clk_sys) disable iff (!rst_n) pkt_abort);
  c_pause: cover property (@(posedge clk_sys) disable iff (!rst_n) pause_req ##1 !pause_req);

endmodule

// file: tb/gtc_far_model.sv
/*
  Far side of the transmit path: a gapless packet source, a collision pin
  and a pause frame sender.
  Assumes the transmit control block runs on the same clock.
*/
`timescale 1ns/100ps

module gtc_far_model
  import gtc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [7:0] len,
  input wire logic [7:0] col_at,
  input wire logic src_ready,
  input wire logic pkt_end,
  input wire logic pause_req,
  output gtc_beat_t src_beat,
  output logic src_valid,
  output logic phy_col,
  output logic pause_sent
);
  logic [7:0] idx_r;
  logic [2:0] pcnt_r;

  // Streams bytes 0 to len-1, one per accepted cycle, until the last one.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idx_r <= 8'h00;
      src_valid <= 1'b0;
    end
    else if (start)
    begin
      idx_r <= 8'h00;
      src_valid <= 1'b1;
    end
    else if (pkt_end || (src_valid && src_ready && src_beat.last))
      src_valid <= 1'b0;
    else if (src_valid && src_ready)
      idx_r <= idx_r + 8'h01;
  end

  // Idle data lines show the inverse so a stale byte never looks valid.
  assign src_beat = {src_valid ? idx_r : ~idx_r, src_valid && (idx_r == len - 8'h01)};

  // Collision burst of four byte times starting at byte col_at.
  assign phy_col = src_valid && (col_at != 8'h00) && (idx_r >= col_at) && (idx_r < col_at + 8'h04);

  // Sends the pause frame a few cycles after the request rises.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pcnt_r <= 3'h0;
    else if (!pause_req)
      pcnt_r <= 3'h0;
    else if (pcnt_r != 3'h7)
      pcnt_r <= pcnt_r + 3'h1;
  end
  assign pause_sent = (pcnt_r == 3'h4);
endmodule

// file: tb/gtc_tx_ctrl_tb.sv
/*
  Self-checking bench of the transmit control block.
  Assumes the far-side model drives the packet source, collisions and pause.
*/
`timescale 1ns/100ps

module gtc_tx_ctrl_tb
  import gtc_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic nvm_load = 1'b0;
  logic [15:0] nvm_word = 16'h0000;
  logic fetch_want = 1'b0;
  logic fetch_done = 1'b0;
  logic fetch_req;
  gtc_beat_t src_beat;
  logic src_valid, src_ready, phy_col, pkt_done, pkt_retry, pkt_abort;
  gtc_gmii_t phy_tx;
  logic [15:0] pause_timer_value = 16'h1234;
  logic pause_sent, pause_req;
  logic [15:0] pause_time;
  logic start = 1'b0;
  logic [7:0] len = 8'h01;
  logic [7:0] col_at = 8'h00;
  int error_cnt = 0;
  int n_tests = 0;
  int n_dat = 0, n_ext = 0, n_bad = 0, n_req = 0, n_ps = 0, d0, e0, r0;

  always #5 clk_sys = ~clk_sys;

  gtc_tx_ctrl i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .nvm_load(nvm_load), .nvm_word(nvm_word), .fetch_want(fetch_want),
    .fetch_done(fetch_done), .fetch_req(fetch_req), .src_beat(src_beat),
    .src_valid(src_valid), .src_ready(src_ready), .phy_tx(phy_tx), .phy_col(phy_col),
    .pkt_done(pkt_done), .pkt_retry(pkt_retry), .pkt_abort(pkt_abort),
    .pause_timer_value(pause_timer_value), .pause_sent(pause_sent),
    .pause_req(pause_req), .pause_time(pause_time));

  gtc_far_model i_far (.clk_sys(clk_sys), .rst_n(rst_n), .start(start), .len(len),
    .col_at(col_at), .src_ready(src_ready), .pkt_end(pkt_retry | pkt_abort),
    .pause_req(pause_req), .src_beat(src_beat), .src_valid(src_valid),
    .phy_col(phy_col), .pause_sent(pause_sent));

  // Counts data bytes, extension symbols, malformed symbols, reads and pauses.
  always @(posedge clk_sys)
  begin
    if (phy_tx.en === 1'b1) n_dat++;
    if (phy_tx.er === 1'b1 && phy_tx.en === 1'b0) n_ext++;
    if (phy_tx.er === 1'b1 && (phy_tx.en !== 1'b0 || phy_tx.data !== 8'h0f)) n_bad++;
    if (fetch_req === 1'b1) n_req++;
    if (pause_sent) n_ps++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Reads one register and compares it in the cycle after the strobe.
  task automatic rc(input logic [15:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
    @(posedge clk_sys);
  endtask

  // Sends one packet, waits for its outcome, then lets back-off run out.
  task automatic pk(input logic [7:0] n, input logic [7:0] c, input logic [2:0] exp,
                    input int ext);
    logic [2:0] res;
    d0 = n_dat;
    e0 = n_ext;
    len <= n;
    col_at <= c;
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    res = 3'b000;
    for (int k = 0; k < 3000 && res == 3'b000; k++)
    begin
      @(posedge clk_sys);
      #1 res = {pkt_done, pkt_retry, pkt_abort};
    end
    repeat (300) @(posedge clk_sys);
    chk(res, exp);
    if (exp == 3'b100)
    begin
      chk(n_dat - d0, n);
      chk(n_ext - e0, ext);
    end
  endtask

  task automatic fetch(input int exp);
    r0 = n_req;
    fetch_want <= 1'b1;
    repeat (12) @(posedge clk_sys);
    fetch_want <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(n_req - r0, exp);
  endtask

  task automatic summarize();
    if (error_cnt == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog sized well beyond the expected run of under five thousand cycles.
  initial
  begin
    #500000;
    error_cnt++;
    summarize();
  end

  // Main sequence.
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rc(16'h0400, 32'h1000_0000);
    rc(16'h0404, 32'h0000_0000);
    rc(16'h0410, 32'h0000_0000);
    wr(16'h0408, 32'h0000_0005);
    rc(16'h0408, 32'h0000_0005);
    wr(16'h0400, 32'h1fff_ffff);
    rc(16'h0400, 32'h1d7f_fff0);
    repeat (20) @(posedge clk_sys);
    chk(n_ps, 1);
    chk(pause_req, 1'b0);
    chk(pause_time, 16'h1234);
    rc(16'h0400, 32'h1d3f_fff0);
    wr(16'h0404, 32'h000f_fc00);
    rc(16'h0404, 32'h000f_fc00);
    nvm_load <= 1'b1;
    @(posedge clk_sys);
    nvm_load <= 1'b0;
    rc(16'h0400, 32'h0d3f_fff0);
    fetch(1);
    fetch_done <= 1'b1;
    @(posedge clk_sys);
    fetch_done <= 1'b0;
    fetch(1);
    nvm_word <= 16'h4000;
    nvm_load <= 1'b1;
    @(posedge clk_sys);
    nvm_load <= 1'b0;
    fetch(3);
    rc(16'h040c, 32'h0000_0004);
    wr(16'h0400, 32'h1003_f0f0);
    wr(16'h0404, 32'h0000_0000);
    wr(16'h0408, 32'h4);
    pk(8'd10, 8'd0, 3'b100, 54);
    wr(16'h0408, 32'h5);
    pk(8'd10, 8'd0, 3'b100, 54);
    wr(16'h0408, 32'h3);
    pk(8'd10, 8'd0, 3'b100, 0);
    wr(16'h0408, 32'h5);
    wr(16'h0404, 32'h0001_0000);
    pk(8'd10, 8'd0, 3'b100, 55);
    wr(16'h0404, 32'h0000_0000);
    wr(16'h0408, 32'h0);
    pk(8'd100, 8'd80, 3'b100, 0);
    wr(16'h0400, 32'h1103_f0f0);
    pk(8'd100, 8'd80, 3'b010, 0);
    pk(8'd100, 8'd0, 3'b100, 0);
    wr(16'h0408, 32'h3);
    pk(8'd100, 8'd80, 3'b100, 0);
    wr(16'h0408, 32'h4);
    wr(16'h0400, 32'h1003_f0f0);
    pk(8'd200, 8'd150, 3'b010, 0);
    pk(8'd200, 8'd0, 3'b100, 0);
    wr(16'h0400, 32'h1003_f010);
    pk(8'd20, 8'd5, 3'b001, 0);
    chk(n_bad, 0);
    summarize();
  end
endmodule
